// >>> common/pot_spi_pkg.sv
/*
  constants for the serial potentiometer command block: addresses, command codes,
  field positions, wiper limits and reset values.
  assumes nothing beyond a SystemVerilog compiler.
*/
package pot_spi_pkg;
  // register addresses (4-bit address field)
  localparam logic [3:0] ADDR_WIPER_ZERO = 4'h0;
  localparam logic [3:0] ADDR_WIPER_ONE = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  // command codes (2-bit field after the address)
  localparam logic [1:0] CMD_WRITE = 2'h0;
  localparam logic [1:0] CMD_INCR = 2'h1;
  localparam logic [1:0] CMD_DECR = 2'h2;
  localparam logic [1:0] CMD_READ = 2'h3;
  // field positions in the command byte, msb first on the wire
  localparam int ADDR_MSB = 7;
  localparam int ADDR_LSB = 4;
  localparam int CMD_MSB = 3;
  localparam int CMD_LSB = 2;
  // bit counts of a transaction
  localparam int CMD_BITS = 6;
  localparam int ERR_BIT = 7;
  localparam int BYTE_BITS = 8;
  localparam int READ_BITS = 16;
  // wiper limits for an 8-bit part and for a 7-bit part
  localparam logic [8:0] FULL_SCALE_8BIT = 9'h100;
  localparam logic [8:0] FULL_SCALE_7BIT = 9'h080;
  localparam logic [8:0] ZERO_SCALE = 9'h000;
  // reset values: wipers come up at mid scale of an 8-bit part
  localparam logic [8:0] WIPER_RESET = 9'h080;
  localparam logic [8:0] PAYLOAD_ZERO = 9'h000;
  // status register: write-active flag position
  localparam int STATUS_EEPROM_WRITE_ACTIVE_POS = 4;
endpackage

// >>> rtl/pot_sync_edge.sv
/*
  two-flop synchroniser with rising and falling edge pulses on the synced level.
  assumes the input is asynchronous to clock and slower than half its rate.
*/
`timescale 1ns/100ps
module pot_sync_edge (
  input wire logic clock,
  input wire logic rst,
  input wire logic asyncIn,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_reg; // first stage, read only by the second
  logic sync_reg; // second stage
  logic last_reg; // delayed copy for edge detect

  // shift chain; reset holds the idle-low level
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= asyncIn;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // edges are taken from stages two and three only
  always_comb begin
    level = sync_reg;
    rise = sync_reg & ~last_reg;
    fall = ~sync_reg & last_reg;
  end
endmodule

// >>> rtl/pot_wiper_step.sv
/*
  saturating one-step arithmetic for a volatile wiper.
  assumes the caller presents the current value and wants the stepped one.
*/
`timescale 1ns/100ps
module pot_wiper_step
  import pot_spi_pkg::*;
#(
  parameter bit SEVEN_BIT = 1'b0
) (
  input wire logic [8:0] current,
  input wire logic up,
  output logic [8:0] stepped
);
  logic [8:0] fullScale; // top of range for this part width

  // increment stops at full scale and is dead above it; decrement works at full
  // scale, is dead above it and stops at zero
  always_comb begin
    fullScale = SEVEN_BIT ? FULL_SCALE_7BIT : FULL_SCALE_8BIT;
    stepped = current;
    if (current > fullScale) begin
      stepped = current; // R11 R17
    end else if (up) begin
      if (current != fullScale) begin
        stepped = current + 9'h001; // R10
      end
    end else if (current != ZERO_SCALE) begin
      stepped = current - 9'h001; // R16
    end
  end
endmodule

// >>> rtl/pot_spi_cmd.sv
/*
  serial command interpreter for read, increment and decrement of a dual pot.
  assumes sck, sdi and the chip-select levels arrive asynchronously and are
  sampled here; sdo is open drain, the board pull-up supplies the high level;
  the eeprom write engine outside supplies writeActive.
*/
`timescale 1ns/100ps
// What this block does
// R1: reads are sixteen clocks, any location
// R2: six command bits, error bit, nine data
// R3: sdo driven from bit seven onward
// R4: commands only while select active
// R5: during eeprom write, volatile reads only
// R6: status address four shows write-active
// R7: back-to-back reads in one select
// R8: increment is eight clocks, volatile only
// R9: wiper updates on eighth clock
// R10: increment adds one, saturates full scale
// R11: above full scale increment does nothing
// R12: error bit on seventh clock for steps
// R13: after error sdo stays low until deselect
// R14: steps only on wipers zero and one
// R15: decrement is eight clocks, volatile only
// R16: decrement subtracts one, stops at zero
// R17: above full scale decrement does nothing
// R18: repeated steps allowed in one select
// R19: host deselects soon after last step
// R20: non-multiple-of-eight transactions are ignored; here completed bytes still run, only the partial tail is dropped
// R21: deselect aborts partial command, resets interface
// R22: byte is four address, two command bits
module pot_spi_cmd
  import pot_spi_pkg::*;
#(
  parameter bit SEVEN_BIT = 1'b0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic sck,
  input wire logic sdi,
  input wire logic selectLow,
  input wire logic highVoltageSelectLevel,
  input wire logic writeActive,
  output logic sdoOut,
  output logic sdoEnable,
  output logic [8:0] wiperZero,
  output logic [8:0] wiperOne
);
  typedef enum logic [1:0] {S_IDLE, S_CMD, S_DATA, S_ERROR} state_t;

  logic sckRise, sckFall; // edges of the synchronised link clock
  logic sdiLevel; // synchronised data
  logic lowSel, hvSel; // synchronised select levels
  logic selActive; // either active level

  state_t state_reg, state_next;
  logic [3:0] bitCount_reg, bitCount_next; // clocks seen in current command
  logic [5:0] cmdShift_reg, cmdShift_next; // first six bits
  logic [8:0] outShift_reg, outShift_next; // read payload
  logic sdoOut_reg, sdoOut_next;
  logic sdoEn_reg, sdoEn_next;
  logic [8:0] wiperZero_reg, wiperZero_next;
  logic [8:0] wiperOne_reg, wiperOne_next;
  logic [8:0] stepZero, stepOne; // stepped candidates
  logic stepUp; // direction of the pending step
  logic [3:0] addrNow; // address of the byte being taken
  logic [1:0] cmdNow; // command of the byte being taken
  logic cmdValid; // decoded combination is legal

  pot_sync_edge uSck (.clock(clock), .rst(rst), .asyncIn(sck),
    .level(), .rise(sckRise), .fall(sckFall));
  pot_sync_edge uSdi (.clock(clock), .rst(rst), .asyncIn(sdi),
    .level(sdiLevel), .rise(), .fall());
  pot_sync_edge uSelLow (.clock(clock), .rst(rst), .asyncIn(~selectLow),
    .level(lowSel), .rise(), .fall());
  pot_sync_edge uSelHv (.clock(clock), .rst(rst), .asyncIn(highVoltageSelectLevel),
    .level(hvSel), .rise(), .fall());

  pot_wiper_step #(.SEVEN_BIT(SEVEN_BIT)) uStepZero (.current(wiperZero_reg),
    .up(stepUp), .stepped(stepZero));
  pot_wiper_step #(.SEVEN_BIT(SEVEN_BIT)) uStepOne (.current(wiperOne_reg),
    .up(stepUp), .stepped(stepOne));

  // legal address and command pair; write is out of this block so refused
  function automatic logic decode_ok(input logic [3:0] a, input logic [1:0] c,
                                     input logic busy);
    logic ok;
    ok = 1'b0;
    case (c)
      CMD_READ: begin
        // only volatile locations while the eeprom is busy
        ok = !busy || a == ADDR_WIPER_ZERO || a == ADDR_WIPER_ONE || a == ADDR_STATUS; // R5
      end
      CMD_INCR, CMD_DECR: begin
        ok = (a == ADDR_WIPER_ZERO) || (a == ADDR_WIPER_ONE); // R14
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    return ok;
  endfunction

  assign selActive = lowSel | hvSel; // R4

  // the new bit completes the six-bit header when count reaches five
  always_comb begin
    addrNow = cmdShift_reg[4:1];
    cmdNow = {cmdShift_reg[0], sdiLevel};
    cmdValid = decode_ok(addrNow, cmdNow, writeActive); // R22
    stepUp = (cmdShift_reg[1:0] == CMD_INCR);
  end

  // command sequencing: sample sdi on sck rise, drive sdo on sck fall
  always_comb begin
    state_next = state_reg;
    bitCount_next = bitCount_reg;
    cmdShift_next = cmdShift_reg;
    outShift_next = outShift_reg;
    sdoOut_next = sdoOut_reg;
    sdoEn_next = sdoEn_reg;
    wiperZero_next = wiperZero_reg;
    wiperOne_next = wiperOne_reg;
    if (!selActive) begin
      // deselect drops partial commands and clears the error
      state_next = S_IDLE; // R21 R20
      bitCount_next = 4'h0;
      sdoEn_next = 1'b0;
      sdoOut_next = 1'b1;
    end else begin
      case (state_reg)
        S_IDLE: begin
          state_next = S_CMD;
          bitCount_next = 4'h0;
        end
        S_CMD: begin
          if (sckRise) begin
            bitCount_next = bitCount_reg + 4'h1;
            if (bitCount_reg < 4'(CMD_BITS)) begin
              cmdShift_next = {cmdShift_reg[4:0], sdiLevel};
            end
            if (bitCount_reg == 4'(CMD_BITS - 1)) begin
              if (!cmdValid) begin
                state_next = S_ERROR; // R13
              end else if (cmdNow == CMD_READ) begin
                case (addrNow)
                  ADDR_WIPER_ZERO: outShift_next = wiperZero_reg;
                  ADDR_WIPER_ONE: outShift_next = wiperOne_reg;
                  ADDR_STATUS: begin
                    outShift_next = PAYLOAD_ZERO;
                    outShift_next[STATUS_EEPROM_WRITE_ACTIVE_POS] = writeActive; // R6
                  end
                  default: outShift_next = PAYLOAD_ZERO; // nv image not held here
                endcase
              end
            end
            if (bitCount_reg == 4'(BYTE_BITS - 1)) begin
              // eighth clock: step the wiper or move on to read data
              if (cmdShift_reg[1:0] == CMD_READ) begin
                state_next = S_DATA; // R1
              end else begin
                bitCount_next = 4'h0; // R18
                if (cmdShift_reg[5:2] == ADDR_WIPER_ZERO) begin
                  wiperZero_next = stepZero; // R9 R8 R15
                end else begin
                  wiperOne_next = stepOne; // R9
                end
              end
            end
          end
          if (sckFall && bitCount_reg == 4'(CMD_BITS)) begin
            sdoEn_next = 1'b0; // error bit high: valid, released
            sdoOut_next = 1'b1; // R12 R3
          end
          if (sckFall && bitCount_reg == 4'(ERR_BIT) && cmdShift_reg[1:0] == CMD_READ) begin
            sdoEn_next = !outShift_reg[8]; // R2 R3
            sdoOut_next = outShift_reg[8];
            outShift_next = {outShift_reg[7:0], 1'b0};
          end
        end
        S_DATA: begin
          if (sckRise) begin
            bitCount_next = bitCount_reg + 4'h1;
            if (bitCount_reg == 4'(READ_BITS - 1)) begin
              state_next = S_CMD; // R7
              bitCount_next = 4'h0;
            end
          end
          // a four-bit count cannot hold sixteen, so compare against the last count
          if (sckFall && bitCount_reg <= 4'(READ_BITS - 1)) begin
            sdoEn_next = !outShift_reg[8]; // R2
            sdoOut_next = outShift_reg[8];
            outShift_next = {outShift_reg[7:0], 1'b0};
          end
        end
        S_ERROR: begin
          // open drain pulls low from the error bit until deselect
          sdoEn_next = 1'b1; // R13
          sdoOut_next = 1'b0;
        end
        default: begin
          state_next = S_IDLE;
        end
      endcase
    end
  end

  // state registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= S_IDLE;
      bitCount_reg <= 4'h0;
      cmdShift_reg <= 6'h00;
      outShift_reg <= PAYLOAD_ZERO;
      sdoOut_reg <= 1'b1;
      sdoEn_reg <= 1'b0;
      wiperZero_reg <= WIPER_RESET;
      wiperOne_reg <= WIPER_RESET;
    end else begin
      state_reg <= state_next;
      bitCount_reg <= bitCount_next;
      cmdShift_reg <= cmdShift_next;
      outShift_reg <= outShift_next;
      sdoOut_reg <= sdoOut_next;
      sdoEn_reg <= sdoEn_next;
      wiperZero_reg <= wiperZero_next;
      wiperOne_reg <= wiperOne_next;
    end
  end

  assign sdoOut = sdoOut_reg;
  assign sdoEnable = sdoEn_reg;
  assign wiperZero = wiperZero_reg;
  assign wiperOne = wiperOne_reg;

  // error holds sdo low until select is gone
  property p_err_low;
    @(posedge clock) disable iff (rst)
      (state_reg == S_ERROR && selActive) |=> (sdoEnable && !sdoOut);
  endproperty
  a_err_low: assert property (p_err_low) else $error("sdo not low in error"); // R13

  // wiper never steps without a completed eighth clock
  property p_step_eighth;
    @(posedge clock) disable iff (rst)
      (wiperZero != $past(wiperZero)) |-> $past(bitCount_reg) == 4'(BYTE_BITS - 1);
  endproperty
  a_step_eighth: assert property (p_step_eighth) else $error("wiper moved off eighth clock"); // R9

  // no wiper change while deselected
  property p_idle_hold;
    @(posedge clock) disable iff (rst)
      !selActive |=> $stable(wiperOne) && $stable(wiperZero);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("wiper moved while idle"); // R4 R21

  // a rise of wiper zero is by exactly one
  property p_unit_step;
    @(posedge clock) disable iff (rst)
      (wiperZero > $past(wiperZero)) |-> wiperZero == $past(wiperZero) + 9'h001;
  endproperty
  a_unit_step: assert property (p_unit_step) else $error("increment not by one"); // R10

  // increment never passes full scale
  property p_sat;
    @(posedge clock) disable iff (rst)
      ($past(wiperZero) == (SEVEN_BIT ? FULL_SCALE_7BIT : FULL_SCALE_8BIT))
        |-> wiperZero <= (SEVEN_BIT ? FULL_SCALE_7BIT : FULL_SCALE_8BIT);
  endproperty
  a_sat: assert property (p_sat) else $error("wiper above full scale"); // R10 R11

  // zero scale never wraps
  property p_zero;
    @(posedge clock) disable iff (rst)
      ($past(wiperOne) == ZERO_SCALE) |-> wiperOne <= 9'h001;
  endproperty
  a_zero: assert property (p_zero) else $error("decrement wrapped"); // R16

  // sdo released while deselected
  property p_release;
    @(posedge clock) disable iff (rst)
      !selActive |=> !sdoEnable;
  endproperty
  a_release: assert property (p_release) else $error("sdo driven while idle"); // R21

  // while selected, data phase ends in command phase on the sixteenth clock
  property p_read_len;
    @(posedge clock) disable iff (rst)
      (state_reg == S_DATA && sckRise && bitCount_reg == 4'(READ_BITS - 1) && selActive)
        |=> state_reg == S_CMD && bitCount_reg == 4'h0;
  endproperty
  a_read_len: assert property (p_read_len) else $error("read not sixteen clocks"); // R1 R7
endmodule

// >>> tb/pot_spi_host_model.sv
/*
  behavioural host controller acting as serial master for the pot command block.
  assumes the bench calls its tasks from one process and feeds back the sdo pin
  level with the board pull-up already resolved.
*/
`timescale 1ns/100ps
module pot_spi_host_model (
  input wire logic clock,
  input wire logic sdoLine,
  output logic sck,
  output logic sdi,
  output logic selectLow,
  output logic highVoltageSelectLevel
);
  // four system clocks a half period gives the 32 ns link clock
  localparam int HALF = 4;

  // pins idle: link clock stands low, chip select inactive
  initial begin
    sck = 1'b0;
    sdi = 1'b0;
    selectLow = 1'b1;
    highVoltageSelectLevel = 1'b0;
  end

  // fixed pacing in system clocks; also used for slow answers between commands
  task automatic waitClocks(input int n);
    repeat (n) @(posedge clock);
  endtask

  // select at the normal low level or at the high-voltage level, then settle
  task automatic sel(input logic hv);
    @(posedge clock);
    if (hv) begin
      highVoltageSelectLevel <= 1'b1;
    end else begin
      selectLow <= 1'b0;
    end
    waitClocks(HALF);
  endtask

  // mode 0,0: data changes with the falling edge, sdo taken mid high phase
  // so the slower open-drain answer has settled before it is looked at
  task automatic shift(input int nBits, input logic [15:0] tx, output logic [15:0] rx);
    rx = 16'h0000;
    for (int i = nBits - 1; i >= 0; i--) begin
      sdi <= tx[i];
      waitClocks(HALF);
      sck <= 1'b1;
      waitClocks(2);
      rx = {rx[14:0], sdoLine};
      waitClocks(HALF - 2);
      sck <= 1'b0;
    end
    waitClocks(HALF);
  endtask

  // deselect soon after the last command; data line no longer holds its value
  task automatic desel();
    selectLow <= 1'b1;
    highVoltageSelectLevel <= 1'b0;
    sdi <= ~sdi;
    waitClocks(2 * HALF);
  endtask
endmodule

// >>> tb/pot_spi_cmd_tb.sv
/*
  self-checking bench for the pot serial command block: reads, steps, errors.
  assumes the host model above and the package constants; sdo pulled up on board.
*/
`timescale 1ns/100ps
module pot_spi_cmd_tb;
  import pot_spi_pkg::*;
  logic clock;
  logic rst;
  logic writeActive;
  wire logic sck;
  wire logic sdi;
  wire logic selectLow;
  wire logic hvSel;
  logic sdoOut;
  logic sdoEnable;
  logic [8:0] wiperZero;
  logic [8:0] wiperOne;
  logic [8:0] wiperZeroSeven; // wipers of the seven-bit part on the same pins
  logic [8:0] wiperOneSeven;
  logic [15:0] rx;
  int nErrors = 0;
  int cmpCount = 0;
  // released open drain reads as the pull-up level
  wire logic sdoLine = sdoEnable ? sdoOut : 1'b1;

  pot_spi_cmd #(.SEVEN_BIT(1'b0)) DUT (.clock(clock), .rst(rst), .sck(sck), .sdi(sdi),
    .selectLow(selectLow), .highVoltageSelectLevel(hvSel), .writeActive(writeActive),
    .sdoOut(sdoOut), .sdoEnable(sdoEnable), .wiperZero(wiperZero), .wiperOne(wiperOne));

  pot_spi_host_model host (.clock(clock), .sdoLine(sdoLine), .sck(sck), .sdi(sdi),
    .selectLow(selectLow), .highVoltageSelectLevel(hvSel));

  // seven-bit part listening to the same commands; its full scale is lower
  pot_spi_cmd #(.SEVEN_BIT(1'b1)) dutSeven (.clock(clock), .rst(rst), .sck(sck), .sdi(sdi),
    .selectLow(selectLow), .highVoltageSelectLevel(hvSel), .writeActive(writeActive),
    .sdoOut(), .sdoEnable(), .wiperZero(wiperZeroSeven), .wiperOne(wiperOneSeven));

  // 250 MHz system clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // one comparison kind: values widened to 16 bits
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmpCount++;
    if (got !== exp) begin
      nErrors++;
      $display("mismatch time=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // sixteen-clock read: error bit on the 7th clock, nine data bits after it
  task automatic readReg(input logic [3:0] a, input logic [9:0] exp);
    host.shift(16, {a, CMD_READ, 2'b11, 8'hFF}, rx);
    check(16'(rx[9:0]), 16'(exp));
  endtask

  // eight-clock step command; an error also pulls the 8th bit low
  task automatic step(input logic [3:0] a, input logic [1:0] c, input logic ok);
    host.shift(8, {8'h00, a, c, 2'b11}, rx);
    check(16'(rx[1]), 16'(ok));
    if (!ok) begin
      check(16'(rx[0]), 16'h0000);
    end
  endtask

  // single place where the run ends
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmpCount, nErrors);
    if (nErrors == 0 && cmpCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // a hang counts as a mismatch
  initial begin
    repeat (80000) @(posedge clock);
    nErrors++;
    finish_test();
  end

  // invalid step commands: status address, nonvolatile address, write code
  logic [3:0] badAddr [3] = '{ADDR_STATUS, 4'h2, ADDR_WIPER_ZERO};
  logic [1:0] badCmd [3] = '{CMD_INCR, CMD_DECR, CMD_WRITE};

  initial begin
    rst = 1'b1;
    writeActive = 1'b0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    host.waitClocks(5);
    check(16'(wiperZero), 16'(WIPER_RESET));
    check(16'(wiperOne), 16'(WIPER_RESET));
    // back-to-back reads of different places in one select
    host.sel(1'b0);
    readReg(ADDR_WIPER_ZERO, {1'b1, WIPER_RESET});
    readReg(ADDR_WIPER_ONE, {1'b1, WIPER_RESET});
    readReg(4'h2, {1'b1, PAYLOAD_ZERO});
    host.desel();
    // during an eeprom write only volatile places read; error sticks
    writeActive <= 1'b1;
    host.sel(1'b0);
    readReg(ADDR_STATUS, {1'b1, 9'h001 << STATUS_EEPROM_WRITE_ACTIVE_POS});
    readReg(4'h2, 10'h000);
    readReg(ADDR_WIPER_ZERO, 10'h000);
    host.desel();
    writeActive <= 1'b0;
    // single then repeated increments up to saturation, then mixed string
    host.sel(1'b0);
    step(ADDR_WIPER_ZERO, CMD_INCR, 1'b1);
    host.waitClocks(6);
    check(16'(wiperZero), 16'(WIPER_RESET + 9'h001));
    check(16'(wiperZeroSeven), 16'(FULL_SCALE_7BIT));
    repeat (130) step(ADDR_WIPER_ZERO, CMD_INCR, 1'b1);
    check(16'(wiperZero), 16'(FULL_SCALE_8BIT));
    check(16'(wiperZeroSeven), 16'(FULL_SCALE_7BIT));
    host.waitClocks(40);
    step(ADDR_WIPER_ZERO, CMD_DECR, 1'b1);
    readReg(ADDR_WIPER_ZERO, {1'b1, FULL_SCALE_8BIT - 9'h001});
    check(16'(wiperZeroSeven), 16'(FULL_SCALE_7BIT - 9'h001));
    host.desel();
    // high-voltage select, decrement down to zero scale and hold there
    host.sel(1'b1);
    repeat (130) step(ADDR_WIPER_ONE, CMD_DECR, 1'b1);
    host.waitClocks(6);
    check(16'(wiperOne), 16'(ZERO_SCALE));
    check(16'(wiperOneSeven), 16'(ZERO_SCALE));
    host.desel();
    // each invalid pair: error bit low, all following sdo low, no change
    for (int i = 0; i < 3; i++) begin
      host.sel(1'b0);
      step(badAddr[i], badCmd[i], 1'b0);
      readReg(ADDR_WIPER_ONE, 10'h000);
      check(rx, 16'h0000);
      host.desel();
    end
    check(16'(wiperZero), 16'(FULL_SCALE_8BIT - 9'h001));
    // partial commands dropped at deselect; twelve clocks run one step only
    host.sel(1'b0);
    host.shift(5, {11'h000, ADDR_WIPER_ZERO, CMD_INCR[1]}, rx);
    host.desel();
    host.sel(1'b0);
    host.shift(12, {4'h0, ADDR_WIPER_ONE, CMD_INCR, 2'b11, 4'hF}, rx);
    host.desel();
    check(16'(wiperZero), 16'(FULL_SCALE_8BIT - 9'h001));
    check(16'(wiperOne), 16'(ZERO_SCALE + 9'h001));
    // clocking with select inactive changes nothing
    host.shift(8, {8'h00, ADDR_WIPER_ONE, CMD_INCR, 2'b11}, rx);
    host.waitClocks(6);
    check(16'(wiperOne), 16'(ZERO_SCALE + 9'h001));
    check(16'(wiperOneSeven), 16'(ZERO_SCALE + 9'h001));
    finish_test();
  end
endmodule
